// file: test_xdpc_checker.sv
// Self-checking bench for the execute-disable page checker
`timescale 1ns/1ns
`default_nettype none
module test_xdpc_checker;
  localparam logic [63:0] XD  = 64'h8000_0000_0000_0000;
  localparam logic [4:0]  OKV = 5'h11;
  localparam logic [4:0]  RSV = 5'h1C;
  localparam logic [4:0]  XDV = 5'h1A;
  logic                    i_mclk = 1'b0;
  logic                    i_srst = 1'b1;
  logic                    psel = 1'b0;
  logic                    pen = 1'b0;
  logic                    pwr = 1'b0;
  logic                    wide = 1'b0;
  logic [11:0]             addr = 12'h000;
  logic [31:0]             wdata = 32'h0;
  logic [31:0]             prdata;
  logic [31:0]             rd;
  logic                    pready;
  logic                    pslverr;
  logic                    err;
  logic                    gpf;
  logic                    xpa;
  xdpc_pkg::xdpc_walk_t    walk_s;
  xdpc_pkg::xdpc_verdict_t verd;
  int                      err_count = 0;
  int                      samples_checked = 0;
  xdpc_checker dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(4'hF), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_wide_mode_active(wide), .i_walk(walk_s),
    .o_verdict(verd), .o_general_protection_fault(gpf), .o_exec_protect_active(xpa));
  xdpc_walk_model wm (.i_mclk(i_mclk), .o_walk(walk_s));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= 20) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk({31'h0, err}, {31'h0, e});
    if (!e) chk(rd, exp);
  endtask
  task automatic walk(input logic [1:0] lv, input logic [2:0] f, input logic [63:0] e,
                      input logic [4:0] exp);
    wm.send(lv, f, e);
    #1;
    if (exp != 5'h00) chk({27'h0, verd}, {27'h0, exp});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_srst <= 1'b0;
    rchk(xdpc_pkg::QUERY_OFF, 32'h2010_0000, 1'b0);
    rchk(xdpc_pkg::CAPCFG_OFF, 32'h3, 1'b0);
    rchk(12'h020, 32'h0, 1'b1);
    apb(1'b1, xdpc_pkg::CTRL4_OFF, 32'h2);
    apb(1'b1, xdpc_pkg::EFR_LO_OFF, 32'hFFFF_FFFF);
    rchk(xdpc_pkg::EFR_LO_OFF, 32'h901, 1'b0);
    rchk(xdpc_pkg::EFR_HI_OFF, 32'h0, 1'b0);
    rchk(xdpc_pkg::STATUS_OFF, 32'h14, 1'b0);
    walk(2'd3, 3'b110, XD, XDV);
    walk(2'd2, 3'b110, XD | 64'h80, XDV);
    walk(2'd2, 3'b010, XD, XDV);
    walk(2'd3, 3'b110, 64'h0, XDV);
    walk(2'd3, 3'b111, XD, OKV);
    walk(2'd3, 3'b100, XD, OKV);
    walk(2'd3, 3'b110, 64'h4000_0000_0000_0000, RSV);
    walk(2'd2, 3'b110, 64'h2080, RSV);
    walk(2'd1, 3'b000, 64'h20, RSV);
    apb(1'b1, xdpc_pkg::EFR_LO_OFF, 32'h0);
    walk(2'd3, 3'b100, XD, RSV);
    apb(1'b1, xdpc_pkg::CAPCFG_OFF, 32'h7);
    walk(2'd3, 3'b100, 64'h0000_0020_0000_0000, RSV);
    apb(1'b1, xdpc_pkg::CAPCFG_OFF, 32'hB);
    walk(2'd3, 3'b100, 64'h0000_0002_0000_0000, RSV);
    apb(1'b1, xdpc_pkg::CAPCFG_OFF, 32'h3);
    apb(1'b1, xdpc_pkg::CTRL4_OFF, 32'h0);
    apb(1'b1, xdpc_pkg::EFR_LO_OFF, 32'h800);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, xpa}, 32'h0);
    walk(2'd3, 3'b110, 64'hFFFF_FFFF_FFFF_FFFF, OKV);
    apb(1'b1, xdpc_pkg::CTRL4_OFF, 32'h1);
    walk(2'd2, 3'b100, 64'h0020_0080, RSV);
    walk(2'd2, 3'b100, 64'h0020_0000, OKV);
    @(posedge i_mclk) wide <= 1'b1;
    apb(1'b1, xdpc_pkg::CTRL4_OFF, 32'h2);
    rchk(xdpc_pkg::STATUS_OFF, 32'h1C, 1'b0);
    chk({31'h0, xpa}, 32'h1);
    rchk(xdpc_pkg::EFR_LO_OFF, 32'hC00, 1'b0);
    for (int l = 0; l < 3; l++) walk(l[1:0], 3'b010, (l == 0) ? XD : 64'h0, XDV);
    walk(2'd3, 3'b110, 64'h0, XDV);
    walk(2'd3, 3'b100, 64'h0000_2000_0000_0000, RSV);
    walk(2'd2, 3'b100, 64'h4080, RSV);
    apb(1'b1, xdpc_pkg::EFR_LO_OFF, 32'h0);
    walk(2'd3, 3'b100, XD, RSV);
    @(posedge i_mclk) wide <= 1'b0;
    apb(1'b1, xdpc_pkg::CAPCFG_OFF, 32'h2);
    apb(1'b1, xdpc_pkg::EFR_LO_OFF, 32'h800);
    #1;
    chk({31'h0, gpf}, 32'h1);
    rchk(xdpc_pkg::EFR_LO_OFF, 32'h0, 1'b0);
    rchk(xdpc_pkg::STATUS_OFF, 32'h12, 1'b0);
    apb(1'b1, xdpc_pkg::CAPCFG_OFF, 32'h0);
    rchk(xdpc_pkg::QUERY_OFF, 32'h0, 1'b0);
    rchk(xdpc_pkg::EFR_LO_OFF, 32'h0, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire

// file: xdpc_checker.sv
// Execute-disable and reserved-bit checker for paging entries, with APB registers
//
// Functional notes
// RULE1: Feature query result bit 20 reads one when execute protection exists.
// RULE2: Protection active only with enable bit 11, capability, extended addressing.
// RULE3: Feature register implemented when query bit 20 or 29 is one.
// RULE4: Setting enable bit without capability raises general protection fault.
// RULE5: Wide-active bit 10, wide-enable bit 8, fast-syscall bit 0, enable bit 11; rest reserved.
// RULE6: Enabled protection forbids fetch from pages whose entry bit 63 set.
// RULE7: Wide mode: any level bit 63 set makes page data only.
// RULE8: Extended-address mode: directory or table bit 63 makes page data only.
// RULE9: Paging mode chosen from extended-address and large-page bits.
// RULE10: Flat modes check nothing except bit 21 of 4 MB directories.
// RULE11: Extended-address pointer entries check bits 63:40, 8:5, 2:1.
// RULE12: Extended-address 2 MB directory checks 62:40 or 63:40 plus 20:13.
// RULE13: Extended-address 4 KB directory and table check 62:40 or 63:40.
// RULE14: Wide mode checks 51:40 everywhere, plus 20:13 for 2 MB directory.
// RULE15: Wide mode without enabled protection also checks bit 63.
// RULE16: Narrow physical address widths also check 39:36 or 39:32.
// RULE17: Execute-disable page fault raised at every privilege level.
// RULE18: Check applies to every kind of instruction fetch.
// RULE19: Bit 63 evaluated only when enabled and filling translation cache miss.
// RULE20: Protection offered only in extended-address protected mode and wide mode.
// RULE21: Reserved-bit violation reported as page fault; access not completed.
`timescale 1ns/1ns
`default_nettype none
module xdpc_checker (
  input  wire logic                 i_mclk,
  input  wire logic                 i_srst,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  input  wire logic                 i_wide_mode_active,
  input  wire xdpc_pkg::xdpc_walk_t i_walk,
  output xdpc_pkg::xdpc_verdict_t   o_verdict,
  output logic                      o_general_protection_fault,
  output logic                      o_exec_protect_active
);
  logic [31:0] efr_r;
  logic [3:0]  capcfg_r;
  logic [1:0]  ctrl4_r;
  logic        wma_r;
  logic        xd_acc_r;
  logic        gp_sticky_r;
  logic [31:0] query;
  logic        cap_xp;
  logic        efr_present;
  logic        xp_active;
  logic        ext_addr;
  logic        large_page;
  logic [1:0]  paw;
  xdpc_pkg::xdpc_pmode_t pmode;
  logic        apb_acc;
  logic        apb_wr;
  logic        wr_efr_lo;
  logic        xpe_set_try;
  logic        xd_now;
  logic        rsvd_now;
  logic        xd_seen;

  // Reserved-bit mask for one entry, by mode, level, size and address width
  function automatic logic [63:0] rsvd_mask(
    input xdpc_pkg::xdpc_pmode_t m,
    input xdpc_pkg::xdpc_level_t lv,
    input logic                  big,
    input logic                  xp,
    input logic [1:0]            w
  );
    logic [63:0] k;
    k = 64'h0;
    case (m)
      xdpc_pkg::PM_FLAT4K: k = 64'h0;
      xdpc_pkg::PM_WIDELP: begin
        if (lv == xdpc_pkg::LVL_DIR && big) k[21] = 1'b1; // RULE10
      end
      xdpc_pkg::PM_EXTADDR: begin
        k[63:40] = {~xp, 23'h7F_FFFF};                  // RULE13
        if (lv == xdpc_pkg::LVL_PTR) begin
          k[63] = 1'b1;                                 // RULE11
          k[8:5] = 4'hF;
          k[2:1] = 2'h3;
        end
        if (lv == xdpc_pkg::LVL_DIR && big) k[20:13] = 8'hFF; // RULE12
      end
      xdpc_pkg::PM_WIDE: begin
        k[51:40] = 12'hFFF;                             // RULE14
        k[63] = ~xp;                                    // RULE15
        if (lv == xdpc_pkg::LVL_DIR && big) k[20:13] = 8'hFF;
      end
      default: k = 64'h0;
    endcase
    if (m != xdpc_pkg::PM_FLAT4K && m != xdpc_pkg::PM_WIDELP) begin
      if (w == xdpc_pkg::PAW_36) k[39:36] = 4'hF;       // RULE16
      else if (w == xdpc_pkg::PAW_32) k[39:32] = 8'hFF;
    end
    return k;
  endfunction

  assign cap_xp      = capcfg_r[xdpc_pkg::CAP_XP_BIT];
  assign query       = {2'h0, capcfg_r[xdpc_pkg::CAP_WIDE_BIT], 8'h00,
                        cap_xp, 20'h0_0000};            // RULE1
  assign efr_present = query[xdpc_pkg::QRY_XP_BIT] | query[xdpc_pkg::QRY_WIDE_BIT]; // RULE3
  assign paw         = capcfg_r[xdpc_pkg::CAP_PAW_LSB +: 2];
  assign ext_addr    = ctrl4_r[xdpc_pkg::EPA_BIT];
  assign large_page  = ctrl4_r[xdpc_pkg::LPE_BIT];

  // Mode select; wide mode implies extended addressing
  always_comb begin
    if (wma_r) pmode = xdpc_pkg::PM_WIDE;
    else if (ext_addr) pmode = xdpc_pkg::PM_EXTADDR;     // RULE9
    else if (large_page) pmode = xdpc_pkg::PM_WIDELP;
    else pmode = xdpc_pkg::PM_FLAT4K;
  end

  assign xp_active = efr_r[xdpc_pkg::XPE_BIT] & cap_xp & (ext_addr | wma_r); // RULE2 RULE20

  // APB: zero-wait slave, every access answered in its access cycle
  assign apb_acc     = i_psel & i_penable;
  assign apb_wr      = apb_acc & i_pwrite;
  assign wr_efr_lo   = apb_wr & (i_paddr == xdpc_pkg::EFR_LO_OFF) & efr_present;
  assign xpe_set_try = wr_efr_lo & i_pstrb[1] & i_pwdata[xdpc_pkg::XPE_BIT] & ~cap_xp;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      efr_r <= xdpc_pkg::EFR_RST;
    end else if (wr_efr_lo && !xpe_set_try) begin
      // Only defined writable bits stored; reserved bits stay zero
      if (i_pstrb[0]) efr_r[xdpc_pkg::FSC_BIT] <= i_pwdata[xdpc_pkg::FSC_BIT]; // RULE5
      if (i_pstrb[1]) begin
        efr_r[xdpc_pkg::WME_BIT] <= i_pwdata[xdpc_pkg::WME_BIT];
        efr_r[xdpc_pkg::XPE_BIT] <= i_pwdata[xdpc_pkg::XPE_BIT];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      capcfg_r <= xdpc_pkg::CAPCFG_RST;
      ctrl4_r  <= xdpc_pkg::CTRL4_RST;
    end else if (apb_wr) begin
      if (i_paddr == xdpc_pkg::CAPCFG_OFF && i_pstrb[0]) capcfg_r <= i_pwdata[3:0];
      if (i_paddr == xdpc_pkg::CTRL4_OFF && i_pstrb[0]) ctrl4_r <= i_pwdata[1:0];
    end
  end

  // Wide-active is set by the core mode logic, not by software
  always_ff @(posedge i_mclk) begin
    if (i_srst) wma_r <= 1'b0;
    else wma_r <= i_wide_mode_active & capcfg_r[xdpc_pkg::CAP_WIDE_BIT];
  end

  // Fault pulse on a refused enable write; sticky copy cleared by write of one
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_general_protection_fault <= 1'b0;
      gp_sticky_r <= 1'b0;
    end else begin
      o_general_protection_fault <= xpe_set_try;      // RULE4
      if (xpe_set_try) gp_sticky_r <= 1'b1;
      else if (apb_wr && i_paddr == xdpc_pkg::STATUS_OFF && i_pstrb[0] && i_pwdata[0])
        gp_sticky_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable) begin
        case (i_paddr)
          xdpc_pkg::EFR_LO_OFF: begin
            o_prdata <= efr_present ? (efr_r | {21'h0, wma_r, 10'h000}) : 32'h0000_0000;
            o_pslverr <= ~efr_present;
          end
          xdpc_pkg::EFR_HI_OFF: o_pslverr <= ~efr_present;
          xdpc_pkg::QUERY_OFF:  o_prdata <= query;
          xdpc_pkg::CAPCFG_OFF: o_prdata <= {28'h000_0000, capcfg_r};
          xdpc_pkg::CTRL4_OFF:  o_prdata <= {30'h0000_0000, ctrl4_r};
          xdpc_pkg::STATUS_OFF: o_prdata <= {27'h0, pmode, xp_active, gp_sticky_r, 1'b0};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Walk checking; an execute-disable bit at any level taints the page
  assign xd_now   = i_walk.fetch & ~i_walk.itc_hit & xp_active
                  & i_walk.entry[xdpc_pkg::XD_BIT];   // RULE19 RULE6
  assign rsvd_now = |(i_walk.entry & rsvd_mask(pmode, i_walk.level,
                    i_walk.entry[xdpc_pkg::PS_BIT], xp_active, paw));
  // Taint carries down the walk in extended and wide modes while protection is on
  assign xd_seen  = xd_acc_r & xp_active;  // RULE7 RULE8

  always_ff @(posedge i_mclk) begin
    if (i_srst) xd_acc_r <= 1'b0;
    else if (i_walk.valid) xd_acc_r <= i_walk.last ? 1'b0 : (xd_seen | xd_now);
  end

  // Privilege plays no part: every fetch kind arrives as the same fetch flag
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_verdict <= '0;
    end else begin
      o_verdict.valid      <= i_walk.valid;
      o_verdict.rsvd_fault <= i_walk.valid & rsvd_now;                  // RULE21
      o_verdict.xd_fault   <= i_walk.valid & (xd_now | xd_seen);        // RULE17 RULE18
      o_verdict.page_fault <= i_walk.valid & (rsvd_now | xd_now | xd_seen);
      o_verdict.complete   <= i_walk.valid & i_walk.last & ~(rsvd_now | xd_now | xd_seen);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) o_exec_protect_active <= 1'b0;
    else o_exec_protect_active <= xp_active;
  end
endmodule
`default_nettype wire

// file: xdpc_checker_props.sv
// Port-level assertions for the execute-disable page checker
`timescale 1ns/1ns
`default_nettype none
module xdpc_checker_props (
  input wire logic                    i_mclk,
  input wire logic                    i_srst,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    i_pwrite,
  input wire logic [11:0]             i_paddr,
  input wire logic [31:0]             i_pwdata,
  input wire logic [3:0]              i_pstrb,
  input wire logic [31:0]             o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    i_wide_mode_active,
  input wire xdpc_pkg::xdpc_walk_t    i_walk,
  input wire xdpc_pkg::xdpc_verdict_t o_verdict,
  input wire logic                    o_general_protection_fault,
  input wire logic                    o_exec_protect_active
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  AST_READY_SETUP: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready missing after setup");
  AST_READY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  AST_VERDICT_LAT: assert property (i_walk.valid |=> o_verdict.valid)
    else $error("verdict missing after entry");
  AST_VERDICT_SPUR: assert property (o_verdict.valid |-> $past(i_walk.valid))
    else $error("verdict without entry");
  AST_PF_SUM: assert property (o_verdict.valid |->
    o_verdict.page_fault == (o_verdict.rsvd_fault || o_verdict.xd_fault))
    else $error("page fault not sum of causes");
  AST_XD_CAUSE: assert property (o_verdict.xd_fault |-> $past(i_walk.fetch) &&
    !$past(i_walk.itc_hit) && o_exec_protect_active)
    else $error("execute fault without cause");
  AST_DONE_CLEAN: assert property (o_verdict.complete |->
    !o_verdict.page_fault && $past(i_walk.last))
    else $error("completion with fault or early");
  AST_GP_PULSE: assert property (o_general_protection_fault |=>
    !o_general_protection_fault)
    else $error("protection fault longer than a pulse");
  cover property (o_verdict.xd_fault);
  cover property (o_verdict.rsvd_fault);
  cover property (o_general_protection_fault);
endmodule
bind xdpc_checker xdpc_checker_props u_props (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_wide_mode_active(i_wide_mode_active), .i_walk(i_walk),
  .o_verdict(o_verdict), .o_general_protection_fault(o_general_protection_fault),
  .o_exec_protect_active(o_exec_protect_active));
`default_nettype wire

// file: xdpc_pkg.sv
// Package for the execute-disable page checker: register map, fields, types
package xdpc_pkg;
  // APB register byte offsets
  localparam logic [11:0] EFR_LO_OFF   = 12'h000;
  localparam logic [11:0] EFR_HI_OFF   = 12'h004;
  localparam logic [11:0] QUERY_OFF    = 12'h008;
  localparam logic [11:0] CAPCFG_OFF   = 12'h00C;
  localparam logic [11:0] CTRL4_OFF    = 12'h010;
  localparam logic [11:0] STATUS_OFF   = 12'h014;
  // Extended feature register field positions
  localparam int FSC_BIT = 0;
  localparam int WME_BIT = 8;
  localparam int WMA_BIT = 10;
  localparam int XPE_BIT = 11;
  // Feature query result bits
  localparam int QRY_XP_BIT   = 20;
  localparam int QRY_WIDE_BIT = 29;
  // Control register four bits held locally
  localparam int LPE_BIT = 0;
  localparam int EPA_BIT = 1;
  // Capability configuration bits
  localparam int CAP_XP_BIT   = 0;
  localparam int CAP_WIDE_BIT = 1;
  localparam int CAP_PAW_LSB  = 2;
  // Entry bit positions
  localparam int XD_BIT  = 63;
  localparam int PS_BIT  = 7;
  // Reset values
  localparam logic [31:0] EFR_RST    = 32'h0000_0000;
  localparam logic [3:0]  CAPCFG_RST = 4'h3;
  localparam logic [1:0]  CTRL4_RST  = 2'h0;
  // Physical address width selections
  localparam logic [1:0] PAW_40 = 2'h0;
  localparam logic [1:0] PAW_36 = 2'h1;
  localparam logic [1:0] PAW_32 = 2'h2;

  typedef enum logic [1:0] {
    LVL_TOP, LVL_PTR, LVL_DIR, LVL_TBL
  } xdpc_level_t;

  typedef enum logic [1:0] {
    PM_FLAT4K, PM_WIDELP, PM_EXTADDR, PM_WIDE
  } xdpc_pmode_t;

  typedef struct packed {
    logic        valid;
    xdpc_level_t level;
    logic        last;
    logic        fetch;
    logic        itc_hit;
    logic [63:0] entry;
  } xdpc_walk_t;

  typedef struct packed {
    logic valid;
    logic page_fault;
    logic rsvd_fault;
    logic xd_fault;
    logic complete;
  } xdpc_verdict_t;
endpackage

// file: xdpc_walk_model.sv
// Behavioural page walker that hands paging entries to the checker
`timescale 1ns/1ns
`default_nettype none
module xdpc_walk_model (
  input  wire logic            i_mclk,
  output var xdpc_pkg::xdpc_walk_t o_walk
);
  initial o_walk = '0;
  // Flags are {last, fetch, itc_hit}; one entry per call
  task automatic send(input logic [1:0] lv, input logic [2:0] f, input logic [63:0] e);
    @(posedge i_mclk);
    o_walk <= {1'b1, lv, f, e};
    @(posedge i_mclk);
    // Entry inverted once released so a stale value is never mistaken for data
    o_walk <= {1'b0, lv, f, ~e};
  endtask
endmodule
`default_nettype wire
